// file: rtl/accel_readout.sv
`timescale 1ns/1ps
`include "accel_readout_cfg.svh"

module sample_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               in_valid,
  output      logic               in_ready,
  input  wire logic [WIDTH-1:0]   in_data,
  output      logic               out_valid,
  input  wire logic               out_ready,
  output      logic [WIDTH-1:0]   out_data,
  output      logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
    $error("sample_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  wire              push;
  wire              pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign count     = wr_ptr_r - rd_ptr_r;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

module accel_readout
  import accel_readout_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int SAMPLE_W   = 12
) (
  input  wire logic    mclk,
  input  wire logic    rst_b,
  input  wire logic    sample_valid,
  output      logic    sample_ready,
  input  wire sample_t sample_x,
  input  wire sample_t sample_y,
  input  wire sample_t sample_z,
  input  wire byte_t   hp_status,
  input  wire logic    bus_start,
  input  wire logic    bus_stop,
  input  wire logic    addr_load,
  input  wire byte_t   addr_in,
  input  wire logic    wr_req,
  input  wire byte_t   wr_data,
  input  wire logic    rd_req,
  output      byte_t   rd_data,
  output      logic    rd_valid,
  output      logic    fifo_output_select
);

  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  if (SAMPLE_W != 12 || FIFO_DEPTH < 2 || CW > `FS_CNT_W) begin
    $error("accel_readout: sample width or FIFO_DEPTH not supported");
  end

  // configuration
  byte_t       data_config_reg_r;
  axis_flags_t flag_en;
  logic        all_en;

  // current sample and flags
  sample_t     cur_x_r;
  sample_t     cur_y_r;
  sample_t     cur_z_r;
  axis_flags_t ready_r;
  axis_flags_t ready_nxt;
  axis_flags_t ovr_r;
  axis_flags_t ovr_nxt;
  logic        comb_ready_r;
  logic        comb_ready_nxt;
  logic        comb_ovr_r;
  logic        comb_ovr_nxt;
  byte_t       sample_flag_reg;
  byte_t       fifo_state;
  byte_t       status_alias;

  // bus side
  bus_state_t  bus_state_r;
  bus_state_t  bus_state_nxt;
  byte_t       ptr_r;
  byte_t       ptr_nxt;
  byte_t       rd_data_r;
  logic        rd_valid_r;
  byte_t       rd_value;
  logic        burst_active;

  // fifo side
  logic [35:0]   fifo_head;
  logic          fifo_out_valid;
  logic          fifo_in_ready;
  logic          fifo_pop;
  logic [CW-1:0] fifo_count;
  logic [2:0]    byte_idx_r;
  logic [2:0]    byte_idx_nxt;
  logic          fifo_ovf_r;
  byte_t         fifo_byte;

  wire sel      = data_config_reg_r[`CFG_FIFO_SEL_BIT];
  wire rd_x_hi  = rd_req & ~sel & (ptr_r == `OFS_X_HI_SHORT | ptr_r == `OFS_X_HI_LONG);
  wire rd_y_hi  = rd_req & ~sel & (ptr_r == `OFS_Y_HI_SHORT | ptr_r == `OFS_Y_HI_LONG);
  wire rd_z_hi  = rd_req & ~sel & (ptr_r == `OFS_Z_HI_SHORT | ptr_r == `OFS_Z_HI_LONG);
  wire [2:0] hb_read = {rd_z_hi, rd_y_hi, rd_x_hi};
  wire rd_narrow_port = rd_req & sel & (ptr_r == `OFS_X_HI_SHORT);
  wire rd_wide_port   = rd_req & sel & (ptr_r == `OFS_X_LO);
  wire fifo_rd        = rd_narrow_port | rd_wide_port;
  wire [2:0] last_idx = rd_narrow_port ? (`FIFO_BYTES_NARROW - 3'h1)
                                       : (`FIFO_BYTES_WIDE - 3'h1);
  wire cfg_wr   = wr_req & (ptr_r == `OFS_DATA_CONFIG);
  assign fifo_output_select = sel;
  assign flag_en = {data_config_reg_r[`CFG_Z_EN_BIT],
                    data_config_reg_r[`CFG_Y_EN_BIT],
                    data_config_reg_r[`CFG_X_EN_BIT]};
  assign all_en  = &flag_en;
  // flags: set wins over a read in the same cycle
  wire [2:0] axis_new = {3{sample_valid}} & flag_en;
  assign ready_nxt = axis_new | (ready_r & ~hb_read);
  assign ovr_nxt   = (axis_new & ready_r) | (ovr_r & ~hb_read);

  wire comb_new  = sample_valid & all_en;
  wire comb_clr  = |hb_read & ~|(ready_nxt & flag_en);
  assign comb_ready_nxt = comb_new | (comb_ready_r & ~comb_clr);
  assign comb_ovr_nxt   = (comb_new & |(ready_r & flag_en))
                        | (comb_ovr_r & ~comb_clr);

  assign sample_flag_reg = {comb_ovr_r, ovr_r, comb_ready_r, ready_r};

  // fifo state byte: overflow, watermark not tracked here, count
  assign fifo_state = {fifo_ovf_r, 1'b0,
                       {(`FS_CNT_W - CW){1'b0}}, fifo_count};

  assign status_alias = sel ? fifo_state : sample_flag_reg;

  // fifo head bytes, layout {z, y, x}
  wire sample_t head_x = fifo_head[11:0];
  wire sample_t head_y = fifo_head[23:12];
  wire sample_t head_z = fifo_head[35:24];

  always_comb begin
    fifo_byte = 8'h00;
    if (fifo_out_valid) begin
      if (rd_narrow_port) begin
        case (byte_idx_r)
          3'h0:    fifo_byte = head_x[11:4];
          3'h1:    fifo_byte = head_y[11:4];
          3'h2:    fifo_byte = head_z[11:4];
          default: fifo_byte = 8'h00;
        endcase
      end else begin
        case (byte_idx_r)
          3'h0:    fifo_byte = {4'h0, head_x[3:0]};
          3'h1:    fifo_byte = head_x[11:4];
          3'h2:    fifo_byte = {4'h0, head_y[3:0]};
          3'h3:    fifo_byte = head_y[11:4];
          3'h4:    fifo_byte = {4'h0, head_z[3:0]};
          3'h5:    fifo_byte = head_z[11:4];
          default: fifo_byte = 8'h00;
        endcase
      end
    end
  end

  // register read selection
  always_comb begin
    rd_value = 8'h00;
    case (ptr_r)
      `OFS_STATUS_SHORT,
      `OFS_STATUS_LONG:  rd_value = status_alias;
      `OFS_X_HI_SHORT:   rd_value = sel ? fifo_byte : cur_x_r[11:4];
      `OFS_Y_HI_SHORT:   rd_value = sel ? 8'h00 : cur_y_r[11:4];
      `OFS_Z_HI_SHORT:   rd_value = sel ? 8'h00 : cur_z_r[11:4];
      `OFS_X_LO:         rd_value = sel ? fifo_byte : {4'h0, cur_x_r[3:0]};
      `OFS_X_HI_LONG:    rd_value = sel ? 8'h00 : cur_x_r[11:4];
      `OFS_Y_LO:         rd_value = sel ? 8'h00 : {4'h0, cur_y_r[3:0]};
      `OFS_Y_HI_LONG:    rd_value = sel ? 8'h00 : cur_y_r[11:4];
      `OFS_Z_LO:         rd_value = sel ? 8'h00 : {4'h0, cur_z_r[3:0]};
      `OFS_Z_HI_LONG:    rd_value = sel ? 8'h00 : cur_z_r[11:4];
      `OFS_SAMPLE_FLAG:  rd_value = sel ? hp_status : sample_flag_reg;
      `OFS_FIFO_STATE:   rd_value = fifo_state;
      `OFS_DATA_CONFIG:  rd_value = data_config_reg_r;
      default:           rd_value = 8'h00;
    endcase
  end

  // fifo byte walk, pop after the last byte of a sample
  assign fifo_pop = fifo_rd & fifo_out_valid & (byte_idx_r == last_idx);

  always_comb begin
    byte_idx_nxt = byte_idx_r;
    if (addr_load || bus_stop) begin
      byte_idx_nxt = 3'h0;
    end else if (fifo_rd && fifo_out_valid) begin
      byte_idx_nxt = fifo_pop ? 3'h0 : byte_idx_r + 3'h1;
    end
  end

  // pointer: reads of a fifo port hold, other reads and all writes auto-increment
  always_comb begin
    ptr_nxt = ptr_r;
    if (bus_stop) begin
      ptr_nxt = `PTR_RESET;
    end else if (addr_load) begin
      ptr_nxt = addr_in;
    end else if (rd_req && !fifo_rd) begin
      ptr_nxt = ptr_r + 8'h01;
    end else if (wr_req) begin
      ptr_nxt = ptr_r + 8'h01;
    end
  end

  // bus transaction tracking; a burst on a fifo port freezes filling
  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      RD_IDLE:   if (bus_start) bus_state_nxt = RD_BURST;
      RD_BURST: begin
        if (bus_stop)      bus_state_nxt = RD_IDLE;
        else if (fifo_rd)  bus_state_nxt = RD_FROZEN;
      end
      RD_FROZEN: begin
        if (bus_stop)       bus_state_nxt = RD_IDLE;
        else if (bus_start) bus_state_nxt = RD_BURST;
      end
      default:   bus_state_nxt = RD_IDLE;
    endcase
  end

  assign burst_active = (bus_state_r == RD_FROZEN);
  wire fifo_in_valid = sample_valid & sel & ~burst_active;
  assign sample_ready = ~sel | (fifo_in_ready & ~burst_active);

  sample_fifo #(
    .WIDTH (36),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({sample_z, sample_y, sample_x}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_head),
    .count     (fifo_count)
  );

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_config_reg_r <= `CFG_RESET;
    end else if (cfg_wr) begin
      data_config_reg_r <= wr_data & `CFG_WR_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_x_r <= '0;
      cur_y_r <= '0;
      cur_z_r <= '0;
    end else if (sample_valid) begin
      cur_x_r <= sample_x;
      cur_y_r <= sample_y;
      cur_z_r <= sample_z;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ready_r      <= `FLAGS_RESET;
      ovr_r        <= `FLAGS_RESET;
      comb_ready_r <= 1'b0;
      comb_ovr_r   <= 1'b0;
    end else begin
      ready_r      <= ready_nxt;
      ovr_r        <= ovr_nxt;
      comb_ready_r <= comb_ready_nxt;
      comb_ovr_r   <= comb_ovr_nxt;
    end
  end

  // fifo overflow: a sample offered while full; cleared by reading the count
  wire rd_fifo_state = rd_req & ((ptr_r == `OFS_FIFO_STATE)
                     | (sel & (ptr_r == `OFS_STATUS_SHORT | ptr_r == `OFS_STATUS_LONG)));
  wire ovf_set = sample_valid & sel & ~fifo_in_ready;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_ovf_r <= 1'b0;
    end else begin
      fifo_ovf_r <= ovf_set | (fifo_ovf_r & ~rd_fifo_state);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_r       <= `PTR_RESET;
      byte_idx_r  <= 3'h0;
      bus_state_r <= RD_IDLE;
      rd_data_r   <= 8'h00;
      rd_valid_r  <= 1'b0;
    end else begin
      ptr_r       <= ptr_nxt;
      byte_idx_r  <= byte_idx_nxt;
      bus_state_r <= bus_state_nxt;
      rd_valid_r  <= rd_req;
      if (rd_req) begin
        rd_data_r <= rd_value;
      end
    end
  end
  assign rd_data  = rd_data_r;
  assign rd_valid = rd_valid_r;

endmodule

// file: rtl/accel_readout_cfg.svh
`ifndef ACCEL_READOUT_CFG_SVH
`define ACCEL_READOUT_CFG_SVH

// register offsets
`define OFS_STATUS_SHORT   8'h00
`define OFS_X_HI_SHORT     8'h01
`define OFS_Y_HI_SHORT     8'h02
`define OFS_Z_HI_SHORT     8'h03
`define OFS_STATUS_LONG    8'h04
`define OFS_X_LO           8'h05
`define OFS_X_HI_LONG      8'h06
`define OFS_Y_LO           8'h07
`define OFS_Y_HI_LONG      8'h08
`define OFS_Z_LO           8'h09
`define OFS_Z_HI_LONG      8'h0a
`define OFS_SAMPLE_FLAG    8'h0b
`define OFS_FIFO_STATE     8'h10
`define OFS_DATA_CONFIG    8'h16

// data config fields
`define CFG_FIFO_SEL_BIT   7
`define CFG_Z_EN_BIT       2
`define CFG_Y_EN_BIT       1
`define CFG_X_EN_BIT       0
`define CFG_WR_MASK        8'h87
`define CFG_RESET          8'h00

// status byte fields
`define ST_COMB_OVR_BIT    7
`define ST_OVR_LSB         4
`define ST_COMB_RDY_BIT    3
`define ST_RDY_LSB         0
`define FLAGS_RESET        3'h0

// fifo state fields
`define FS_OVF_BIT         7
`define FS_CNT_W           6

// auto-increment pointer after reset or stop
`define PTR_RESET          8'h00

// bytes per sample read from the fifo head
`define FIFO_BYTES_NARROW  3'h3
`define FIFO_BYTES_WIDE    3'h6

`endif

// file: rtl/accel_readout_pkg.sv
package accel_readout_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [11:0] sample_t;
  typedef logic [2:0]  axis_flags_t;

  typedef enum logic [2:0] {
    RD_IDLE   = 3'b001,
    RD_BURST  = 3'b010,
    RD_FROZEN = 3'b100
  } bus_state_t;

endpackage

// file: tb/accel_readout_monitor.sv
`timescale 1ns/1ps
module accel_readout_monitor
  import accel_readout_pkg::*;
(
  input wire logic    mclk,
  input wire logic    rst_b,
  input wire logic    sample_valid,
  input wire logic    sample_ready,
  input wire sample_t sample_x,
  input wire sample_t sample_y,
  input wire sample_t sample_z,
  input wire byte_t   hp_status,
  input wire logic    bus_start,
  input wire logic    bus_stop,
  input wire logic    addr_load,
  input wire byte_t   addr_in,
  input wire logic    wr_req,
  input wire byte_t   wr_data,
  input wire logic    rd_req,
  input wire byte_t   rd_data,
  input wire logic    rd_valid,
  input wire logic    fifo_output_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence load_zero_area;
    addr_load && !wr_req && fifo_output_select &&
      (addr_in inside {8'h02, 8'h03} || (addr_in >= 8'h06 && addr_in <= 8'h0a));
  endsequence
  sequence load_low_nibble;
    addr_load && !wr_req && !fifo_output_select && addr_in inside {8'h05, 8'h07, 8'h09};
  endsequence
  sequence load_flags;
    addr_load && !wr_req && !fifo_output_select && addr_in == 8'h0b;
  endsequence
  sequence lone_read;
    rd_req && !addr_load && !bus_stop && !wr_req;
  endsequence
  rd_answer_a: assert property (rd_req |=> rd_valid) else $error("read not answered");
  rd_quiet_a: assert property (!rd_req |=> !rd_valid) else $error("spurious read valid");
  rd_hold_a: assert property (!rd_valid |-> $stable(rd_data)) else $error("read data moved");
  ready_direct_a: assert property (!fifo_output_select |-> sample_ready)
    else $error("sample refused in direct mode");
  sel_by_write_a: assert property ($changed(fifo_output_select) |-> $past(wr_req))
    else $error("select changed without write");
  zero_area_a: assert property (load_zero_area ##1 (lone_read and fifo_output_select)
    |=> rd_data == 8'h00) else $error("fifo mode area not zero");
  low_nibble_a: assert property (load_low_nibble ##1 lone_read |=> rd_data[7:4] == 4'h0)
    else $error("low byte upper nibble set");
  flag_pairs_a: assert property (load_flags ##1 lone_read |=>
    (rd_data[6:4] & ~rd_data[2:0]) == 3'h0 && (!rd_data[3] || rd_data[2:0] != 3'h0))
    else $error("status flag combination impossible");
endmodule

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model
  import accel_readout_pkg::*;
(
  input  wire logic  mclk,
  input  wire byte_t rd_data,
  input  wire logic  rd_valid,
  output      logic  bus_start,
  output      logic  bus_stop,
  output      logic  addr_load,
  output      byte_t addr_in,
  output      logic  wr_req,
  output      byte_t wr_data,
  output      logic  rd_req
);
  initial begin
    {bus_start, bus_stop, addr_load, wr_req, rd_req} = 5'h00;
    addr_in = 8'h00;
    wr_data = 8'h00;
  end
  task automatic open(input byte_t a);
    @(posedge mclk);
    bus_start <= 1'b1;
    addr_load <= 1'b1;
    addr_in   <= a;
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    open(a);
    @(posedge mclk);
    {bus_start, addr_load, wr_req} <= 3'b001;
    addr_in <= ~a;
    wr_data <= d;
    @(posedge mclk);
    wr_req   <= 1'b0;
    wr_data  <= ~d;
    bus_stop <= 1'b1;
    @(posedge mclk);
    bus_stop <= 1'b0;
  endtask
  // back to back reads, bytes collected as they come back
  task automatic rd(input byte_t a, input int n, output byte_t q[$]);
    q = {};
    open(a);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge mclk);
      if (rd_valid === 1'b1) q.push_back(rd_data);
      {bus_start, addr_load} <= 2'b00;
      addr_in  <= ~a;
      rd_req   <= (i < n);
      bus_stop <= (i == n + 1);
    end
    @(posedge mclk);
    bus_stop <= 1'b0;
  endtask
endmodule

// file: tb/tb_accel_readout.sv
`timescale 1ns/1ps
module tb_accel_readout;
  import accel_readout_pkg::*;
  typedef struct {byte_t cfg; sample_t x; sample_t y; sample_t z; byte_t st;} row_t;
  logic    mclk = 1'b0, rst_b = 1'b0, sample_valid = 1'b0;
  logic    sample_ready, rd_valid, fifo_output_select;
  logic    bus_start, bus_stop, addr_load, wr_req, rd_req;
  sample_t sample_x = 12'h000, sample_y = 12'h000, sample_z = 12'h000;
  byte_t   hp_status = 8'h5a;
  byte_t   addr_in, wr_data, rd_data;
  byte_t   q[$];
  byte_t   e[$];
  int      fails = 0, tests_run = 0, cyc = 0, acc;
  row_t    rows[4] = '{'{8'h07, 12'h800, 12'h7ff, 12'h001, 8'h0f},
                       '{8'h03, 12'habc, 12'h123, 12'hfed, 8'h03},
                       '{8'h04, 12'h0f0, 12'hf0f, 12'h555, 8'h04},
                       '{8'h00, 12'h000, 12'hfff, 12'h8a5, 8'h00}};
  sample_t fx[3] = '{12'h123, 12'h456, 12'h789};
  sample_t fy[3] = '{12'habc, 12'hdef, 12'h024};
  sample_t fz[3] = '{12'h135, 12'h9bd, 12'hf00};
  byte_t   za[7] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a};

  accel_readout #(.FIFO_DEPTH(8)) i_accel_readout (.*);
  host_model i_host_model (.*);

  always #2.5 mclk = ~mclk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string n, byte_t seen, byte_t exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic chkq(string n);
    foreach (e[i]) chk($sformatf("%s byte %0d", n, i), q[i], e[i]);
  endtask
  task automatic rd1(byte_t a, byte_t exp);
    i_host_model.rd(a, 1, q);
    chk($sformatf("reg %h", a), q[0], exp);
  endtask
  task automatic put(sample_t x, sample_t y, sample_t z);
    @(posedge mclk);
    sample_valid <= 1'b1;
    {sample_x, sample_y, sample_z} <= {x, y, z};
    @(posedge mclk);
    sample_valid <= 1'b0;
    @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    chk("rd_data in reset", rd_data, 8'h00);
    chk("ready in reset", {7'h0, sample_ready}, 8'h01);
    rst_b <= 1'b1;
    rd1(8'h04, 8'h00);
    foreach (rows[i]) begin
      i_host_model.wr(8'h16, rows[i].cfg);
      put(rows[i].x, rows[i].y, rows[i].z);
      i_host_model.rd(8'h04, 7, q);
      e = '{rows[i].st, {4'h0, rows[i].x[3:0]}, rows[i].x[11:4], {4'h0, rows[i].y[3:0]},
            rows[i].y[11:4], {4'h0, rows[i].z[3:0]}, rows[i].z[11:4]};
      chkq("long burst");
      i_host_model.rd(8'h00, 4, q);
      e = '{8'h00, rows[i].x[11:4], rows[i].y[11:4], rows[i].z[11:4]};
      chkq("short burst");
    end
    // overwrite of an unread sample, then piecewise clearing
    i_host_model.wr(8'h16, 8'h07);
    put(12'h111, 12'h222, 12'h333);
    put(12'h9ab, 12'h456, 12'hcde);
    rd1(8'h0b, 8'hff);
    rd1(8'h00, 8'hff);
    rd1(8'h04, 8'hff);
    rd1(8'h01, 8'h9a);
    rd1(8'h0b, 8'hee);
    i_host_model.rd(8'h02, 2, q);
    rd1(8'h0b, 8'h00);
    i_host_model.wr(8'h0b, 8'hff);
    i_host_model.wr(8'h06, 8'h00);
    rd1(8'h06, 8'h9a);
    rd1(8'h09, 8'h0e);
    rd1(8'h04, 8'h00);
    rd1(8'h3f, 8'h00);
    // fifo mode
    i_host_model.wr(8'h16, 8'h87);
    chk("select", {7'h0, fifo_output_select}, 8'h01);
    for (int i = 0; i < 3; i++) put(fx[i], fy[i], fz[i]);
    rd1(8'h00, 8'h03);
    rd1(8'h04, 8'h03);
    rd1(8'h0b, 8'h5a);
    i_host_model.rd(8'h01, 3, q);
    e = '{fx[0][11:4], fy[0][11:4], fz[0][11:4]};
    chkq("narrow fifo");
    i_host_model.rd(8'h05, 6, q);
    e = '{{4'h0, fx[1][3:0]}, fx[1][11:4], {4'h0, fy[1][3:0]}, fy[1][11:4],
          {4'h0, fz[1][3:0]}, fz[1][11:4]};
    chkq("wide fifo");
    foreach (za[i]) rd1(za[i], 8'h00);
    i_host_model.rd(8'h01, 4, q);
    e = '{fx[2][11:4], fy[2][11:4], fz[2][11:4], 8'h00};
    chkq("narrow tail");
    // fill past capacity while the host is idle
    acc = 0;
    @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      sample_valid <= 1'b1;
      sample_x <= {i[3:0], 8'hc3};
      @(posedge mclk);
      if (sample_ready === 1'b1) acc++;
    end
    sample_valid <= 1'b0;
    chk("accepted", acc[7:0], 8'h08);
    rd1(8'h00, 8'h88);
    i_host_model.rd(8'h05, 49, q);
    e = '{8'h03, 8'h0c};
    chkq("drain head");
    chk("drain last", q[43], 8'h7c);
    chk("drain empty", q[48], 8'h00);
    rd1(8'h00, 8'h00);
    // a burst on the fifo port stalls filling until stop
    fork
      i_host_model.rd(8'h01, 2, q);
      begin
        repeat (4) @(posedge mclk);
        chk("frozen ready", {7'h0, sample_ready}, 8'h00);
      end
    join
    @(posedge mclk);
    chk("thawed ready", {7'h0, sample_ready}, 8'h01);
    // reset in mid-run clears flags, select and the fifo
    put(12'h321, 12'h654, 12'h987);
    rst_b <= 1'b0;
    @(posedge mclk);
    rst_b <= 1'b1;
    chk("select after reset", {7'h0, fifo_output_select}, 8'h00);
    rd1(8'h0b, 8'h00);
    rd1(8'h10, 8'h00);
    conclude();
  end
endmodule

bind accel_readout accel_readout_monitor i_accel_readout_monitor (.*);
